// ===== pt_divider.sv
`timescale 1ns/1ns
// Generic wrap-around event divider used by both the prescaler and postscaler.
module pt_divider
  import pt_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Control.
  input wire logic clear_i,
  input wire logic event_i,
  input wire logic [3:0] last_i,
  // Result.
  output logic tick_o
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // ****************************************************************
  // Counting.
  // ****************************************************************

  // Clear beats an event so a write always restarts the ratio cleanly.
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (clear_i) begin
      cnt_next = 4'h0;
    end else if (event_i) begin
      if (cnt_reg >= last_i) begin
        cnt_next = 4'h0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// ===== pt_pkg.sv
package pt_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] PT_ADDR_INTCTL = 8'h0b;
  localparam logic [7:0] PT_ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] PT_ADDR_COUNT = 8'h11;
  localparam logic [7:0] PT_ADDR_CTRL = 8'h12;
  localparam logic [7:0] PT_ADDR_ENABLES = 8'h8c;
  localparam logic [7:0] PT_ADDR_LIMIT = 8'h92;
  localparam logic [7:0] PT_ADDR_FLAG_CLR = 8'h93;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int PT_CTRL_RUN_BIT = 2;
  localparam int PT_MATCH_FLAG_BIT = 1;
  localparam int PT_GIE_BIT = 7;
  localparam int PT_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam logic [7:0] PT_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] PT_FLAGS_WMASK = 8'h4f;
  localparam logic [7:0] PT_CTRL_RST = 8'h00;
  localparam logic [7:0] PT_COUNT_RST = 8'h00;
  localparam logic [7:0] PT_LIMIT_RST = 8'hff;
  localparam logic [7:0] PT_IRQ_RST = 8'h00;
  localparam logic [3:0] PT_PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PT_PRE_DIV16_LAST = 4'hf;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef struct packed {
    logic reserved;
    logic [3:0] output_postscale_select;
    logic timer_run_enable;
    logic [1:0] input_prescale_select;
  } pt_ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pt_bus_type;

  typedef enum logic [1:0] {
    PT_PRE_DIV1 = 2'b00,
    PT_PRE_DIV4 = 2'b01,
    PT_PRE_DIV16 = 2'b10
  } pt_pre_type;

endpackage

// ===== pt_timer.sv
`timescale 1ns/1ns

// Operation
// - Postscale field value plus one divides match events reaching the flag.
// - Control bit 2 runs the counter; cleared it holds its value.
// - Prescale field: 00 divides by 1, 01 by 4, 1x by 16.
// - Counter counts up from 00h and wraps to 00h after equalling period.
// - Period register is readable, writable and resets to FFh.
// - Raw match pulse before the postscaler goes to the serial port.
// - Control bit 7 reads zero; control resets to zero.
// - Prescaler runs from the instruction clock; match sets flag bit 1.
// - Count or control write, or reset, clears prescaler and postscaler.
// - Control write leaves the count value untouched.
// - Count register is readable, writable and resets to zero.
module pt_timer
  import pt_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Instruction-clock tick (one cycle per instruction cycle).
  input wire logic instr_tick_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Events.
  output logic match_pulse_o,
  output logic irq_o
);

  pt_bus_type bus;
  pt_ctrl_type ctrl_reg;
  pt_ctrl_type ctrl_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] limit_reg;
  logic [7:0] limit_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enables_reg;
  logic [7:0] enables_next;
  logic [7:0] intctl_reg;
  logic [7:0] intctl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic match_reg;
  logic match_next;
  logic irq_reg;
  logic irq_next;
  logic div_clear;
  logic pre_event;
  logic pre_tick;
  logic post_tick;
  logic [3:0] pre_last;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ****************************************************************
  // Prescaler and postscaler.
  // ****************************************************************

  // Dividers restart on count or control writes.
  assign div_clear = bus.wr && (bus.addr == PT_ADDR_COUNT || bus.addr == PT_ADDR_CTRL);

  // The prescaler only sees instruction ticks while the timer runs.
  assign pre_event = instr_tick_i && ctrl_reg.timer_run_enable;

  // Prescale ratio selection; code 1x both mean divide by 16.
  always_comb begin
    case (ctrl_reg.input_prescale_select)
      PT_PRE_DIV1: pre_last = 4'h0;
      PT_PRE_DIV4: pre_last = PT_PRE_DIV4_LAST;
      default: pre_last = PT_PRE_DIV16_LAST;
    endcase
  end

  pt_divider u_pre (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(div_clear),
    .event_i(pre_event),
    .last_i(pre_last),
    .tick_o(pre_tick)
  );

  // Postscaler divides raw matches by field plus one.
  pt_divider u_post (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(div_clear),
    .event_i(match_reg),
    .last_i(ctrl_reg.output_postscale_select),
    .tick_o(post_tick)
  );

  // ****************************************************************
  // Counter and registers.
  // ****************************************************************

  // Next-state for counter, control and interrupt registers.
  always_comb begin
    ctrl_next = ctrl_reg;
    count_next = count_reg;
    limit_next = limit_reg;
    flags_next = flags_reg;
    enables_next = enables_reg;
    intctl_next = intctl_reg;
    match_next = 1'b0;
    // The prescaler tick is gated by run so a halted timer holds.
    if (pre_tick && ctrl_reg.timer_run_enable) begin
      if (count_reg == limit_reg) begin
        count_next = 8'h00;
        match_next = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (bus.wr) begin
      case (bus.addr)
        PT_ADDR_COUNT: count_next = bus.wdata;
        PT_ADDR_CTRL: ctrl_next = pt_ctrl_type'(bus.wdata & PT_CTRL_WMASK);
        PT_ADDR_LIMIT: limit_next = bus.wdata;
        PT_ADDR_FLAGS: flags_next = bus.wdata & PT_FLAGS_WMASK;
        PT_ADDR_FLAG_CLR: flags_next = flags_reg & ~bus.wdata;
        PT_ADDR_ENABLES: enables_next = bus.wdata;
        PT_ADDR_INTCTL: intctl_next = bus.wdata;
        default: begin
        end
      endcase
    end
    // Hardware set wins over a same-cycle software clear.
    if (post_tick) begin
      flags_next[PT_MATCH_FLAG_BIT] = 1'b1;
    end
  end

  // Interrupt request needs flag, its enable and both global gates.
  always_comb begin
    irq_next = (|(flags_reg & enables_reg)) && intctl_reg[PT_PERIPHERAL_IRQ_ENABLE_BIT]
      && intctl_reg[PT_GIE_BIT];
  end

  // Read mux; unmapped addresses read zero, bit 7 of control reads zero.
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        PT_ADDR_COUNT: rdata_next = count_reg;
        PT_ADDR_CTRL: rdata_next = ctrl_reg & PT_CTRL_WMASK;
        PT_ADDR_LIMIT: rdata_next = limit_reg;
        PT_ADDR_FLAGS: rdata_next = flags_reg;
        PT_ADDR_ENABLES: rdata_next = enables_reg;
        PT_ADDR_INTCTL: rdata_next = intctl_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register stage; all resets return documented values.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= pt_ctrl_type'(PT_CTRL_RST);
      count_reg <= PT_COUNT_RST;
      limit_reg <= PT_LIMIT_RST;
      flags_reg <= PT_IRQ_RST;
      enables_reg <= PT_IRQ_RST;
      intctl_reg <= PT_IRQ_RST;
      rdata_reg <= 8'h00;
      match_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      limit_reg <= limit_next;
      flags_reg <= flags_next;
      enables_reg <= enables_next;
      intctl_reg <= intctl_next;
      rdata_reg <= rdata_next;
      match_reg <= match_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign match_pulse_o = match_reg;
  assign irq_o = irq_reg;

endmodule

// ===== pt_timer_chk.sv
`timescale 1ns/1ns
module pt_timer_chk
  import pt_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port and events.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic match_pulse_o,
  input wire logic irq_o
);
  logic [7:0] ctrl_reg;
  logic [7:0] lim_reg;
  logic [1:0] gate_reg;
  logic [3:0] off_reg;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow the settings written by software so reads and gating can be judged.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= PT_CTRL_RST;
      lim_reg <= PT_LIMIT_RST;
      gate_reg <= 2'h0;
    end else if (wr_i) begin
      if (addr_i == PT_ADDR_CTRL) ctrl_reg <= wdata_i & PT_CTRL_WMASK;
      if (addr_i == PT_ADDR_LIMIT) lim_reg <= wdata_i;
      if (addr_i == PT_ADDR_INTCTL) gate_reg[1] <= wdata_i[7] & wdata_i[6];
      if (addr_i == PT_ADDR_ENABLES) gate_reg[0] <= wdata_i[1];
    end
  end
  // Cycles since the run bit fell; a tick already in flight may still land.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || ctrl_reg[2]) off_reg <= 4'h0;
    else if (off_reg != 4'hf) off_reg <= off_reg + 4'h1;
  end
  sequence s_match0;
    match_pulse_o && !wr_i && ctrl_reg[6:3] == 4'h0 && gate_reg == 2'h3;
  endsequence
  sequence s_quiet;
    !wr_i [*2];
  endsequence
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  ctrl_read_a: assert property ($past(rd_i && addr_i == PT_ADDR_CTRL)
    |-> rdata_o == $past(ctrl_reg)) else $error("control readback wrong");
  limit_read_a: assert property ($past(rd_i && addr_i == PT_ADDR_LIMIT)
    |-> rdata_o == $past(lim_reg)) else $error("period readback wrong");
  flags_rsv_a: assert property ($past(rd_i && addr_i == PT_ADDR_FLAGS)
    |-> rdata_o[7] == 1'b0 && rdata_o[5:4] == 2'h0) else $error("reserved flags set");
  run_halt_a: assert property (off_reg > 4'h3 |-> !match_pulse_o)
    else $error("match while halted");
  irq_gate_a: assert property (irq_o |-> gate_reg == 2'h3 || $past(gate_reg) == 2'h3)
    else $error("irq without enables");
  irq_rise_a: assert property (s_match0 ##1 s_quiet |-> ##[0:1] irq_o)
    else $error("match did not raise irq");
  irq_hold_a: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o)
    else $error("irq dropped by itself");
endmodule
bind pt_timer pt_timer_chk pt_timer_chk_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .match_pulse_o(match_pulse_o), .irq_o(irq_o));

// ===== tb_pt_timer.sv
`timescale 1ns/1ns
module tb_pt_timer
  import pt_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic instr_tick_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic match_pulse_o;
  logic irq_o;
  logic [7:0] v;
  logic [7:0] cv;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  int m;
  int lim;
  pt_timer pt_timer_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .instr_tick_i(instr_tick_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .match_pulse_o(match_pulse_o), .irq_o(irq_o));
  // Bench clock, 50 ns period.
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // Bounded wait for the next match pulse; the count is the spacing in cycles.
  task automatic wait_match(output int c);
    c = 0;
    do begin
      @(posedge ref_clk_i);
      #1 c++;
    end while (match_pulse_o !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      miscompares++;
      finish_test();
    end
  endtask
  function automatic int exp_period(int l, int p);
    return (l + 1) * ((p == 0) ? 1 : ((p == 1) ? 4 : 16));
  endfunction
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk_i);
    #1 chk({7'h0, irq_o}, {7'h0, e});
  endtask
  // Main sequence.
  initial begin
    void'($urandom(32'h19f2));
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdchk(PT_ADDR_COUNT, 8'h00);
    rdchk(PT_ADDR_CTRL, 8'h00);
    rdchk(PT_ADDR_LIMIT, 8'hff);
    rdchk(PT_ADDR_FLAGS, 8'h00);
    wr(PT_ADDR_CTRL, 8'hfb);
    rdchk(PT_ADDR_CTRL, 8'h7b);
    cv = 8'($urandom);
    wr(PT_ADDR_COUNT, cv);
    repeat (10) @(posedge ref_clk_i);
    wr(PT_ADDR_CTRL, 8'h01);
    rdchk(PT_ADDR_COUNT, cv);
    // Every prescale code, with a zero period as the corner case.
    for (int p = 0; p < 4; p++) begin
      lim = (p == 0) ? 0 : $urandom_range(7);
      wr(PT_ADDR_LIMIT, 8'(lim));
      rdchk(PT_ADDR_LIMIT, 8'(lim));
      wr(PT_ADDR_COUNT, 8'h00);
      wr(PT_ADDR_CTRL, 8'h04 | 8'(p));
      wait_match(n);
      wait_match(n);
      chk(8'(n), 8'(exp_period(lim, p)));
    end
    wr(PT_ADDR_INTCTL, 8'hc0);
    wr(PT_ADDR_ENABLES, 8'h02);
    // Postscale ends 1:1 and 1:16 plus one drawn value.
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 0 : ((i == 1) ? 15 : $urandom_range(14));
      wr(PT_ADDR_CTRL, 8'h00);
      wr(PT_ADDR_LIMIT, 8'h03);
      wr(PT_ADDR_COUNT, 8'h00);
      wr(PT_ADDR_FLAG_CLR, 8'h02);
      wr(PT_ADDR_CTRL, 8'(m << 3) | 8'h04);
      n = 0;
      for (int k = 0; k < 200 && irq_o !== 1'b1; k++) begin
        @(posedge ref_clk_i);
        #1 n += (match_pulse_o === 1'b1) ? 1 : 0;
      end
      // A request that never rises is a hang, not a short count.
      if (irq_o !== 1'b1) begin
        miscompares++;
        finish_test();
      end
      chk(8'(n), 8'(m + 1));
    end
    wr(PT_ADDR_INTCTL, 8'h40);
    irq_is(1'b0);
    wr(PT_ADDR_INTCTL, 8'hc0);
    irq_is(1'b1);
    wr(PT_ADDR_CTRL, 8'h00);
    repeat (4) @(posedge ref_clk_i);
    wr(PT_ADDR_FLAG_CLR, 8'h02);
    irq_is(1'b0);
    rdchk(PT_ADDR_FLAGS, 8'h00);
    finish_test();
  end
endmodule
